// File: rtl/hdc_chopper.sv
// module: four-phase hysteresis chopper sequencer with apb registers
//
// How it works
// - phases: on, slow, fast, slow again
// - slow phase lasts 12 plus 32 times setting
// - fast decay length set by comparator
// - start offset widens band, forcing ripple
// - cycle start loads start plus end hysteresis
// - hysteresis steps down every 16 clocks
// - start offset code 0..7 adds 1..8
// - end value is code minus three
// - comparator ignored while blanking
// - blank 16, 24, 36, 54 clocks
// - off setting zero freewheels, chopping stops
// - mode bit one selects classic chopper; here it only stops chopping, bridge off
// - slow phases end only by timer
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module hdc_chopper
  import hdc_pkg::*;
#(
  parameter int TGT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_above,
  output logic [1:0] bridge_drive,
  output logic signed [TGT_W+1:0] cmp_threshold,
  output logic chopper_active
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (TGT_W < 4 || TGT_W > 16) begin : g_bad_width
    $error("hdc_chopper: TGT_W must lie in 4..16");
  end

  // blank length for a select code
  function automatic logic [5:0] blank_len(input logic [1:0] sel);
    case (sel)
      2'd0: blank_len = HDC_BLANK_0;
      2'd1: blank_len = HDC_BLANK_1;
      2'd2: blank_len = HDC_BLANK_2;
      default: blank_len = HDC_BLANK_3;
    endcase
  endfunction : blank_len

  logic [31:0] ctrl_r;
  logic [TGT_W-1:0] target_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic cmp_s1_r;
  logic cmp_s2_r;
  hdc_state_t state_r;
  hdc_state_t state_nxt;
  logic [8:0] slow_cnt_r;
  logic [5:0] blank_cnt_r;
  logic [1:0] bridge_r;
  logic signed [TGT_W+1:0] thresh_r;
  logic active_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = psel && !penable;
  wire acc_wr = psel && penable && pready_r && pwrite;
  wire hit_ctrl = (paddr[11:0] == HDC_OFS_CTRL);
  wire hit_tgt = (paddr[11:0] == HDC_OFS_TARGET);
  wire hit_stat = (paddr[11:0] == HDC_OFS_STATUS);
  wire mapped = (paddr[31:12] == 20'h0_0000) && (hit_ctrl || hit_tgt || hit_stat);
  wire wr_stat_err = pwrite && hit_stat; // status is read only

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire [3:0] slow_set = ctrl_r[HDC_CTRL_SLOW_LSB +: 4];
  wire [1:0] blank_sel = ctrl_r[HDC_CTRL_BLANK_LSB +: 2];
  wire [2:0] hyst_start_code = ctrl_r[HDC_CTRL_HYST_START_LSB +: 3];
  wire [3:0] hyst_end_code = ctrl_r[HDC_CTRL_HYST_END_LSB +: 4];
  wire mode_classic = ctrl_r[HDC_CTRL_MODE_BIT];
  wire run_en = (slow_set != 4'h0) && !mode_classic;
  wire signed [5:0] hyst_end_eff = $signed({2'b00, hyst_end_code}) - HDC_HYST_END_BIAS;
  wire signed [5:0] hyst_start_eff =
    hyst_end_eff + $signed({3'b000, hyst_start_code}) + 6'sh01;
  wire [8:0] slow_len = HDC_SLOW_BASE + {slow_set, 5'b0_0000};

  // ----------------------------------------------------------------
  // hysteresis decrementer
  // ----------------------------------------------------------------
  hdc_hyst_if hy ();
  hdc_hyst_dec u_hyst (
    .pclk(pclk),
    .presetn(presetn),
    .hy(hy)
  );
  wire [31:0] status = {15'h0000, cmp_s2_r, 2'b00, hy.hyst, 5'h00, state_r};

  // ----------------------------------------------------------------
  // sequencing decisions
  // ----------------------------------------------------------------
  wire blanked = (blank_cnt_r != 6'h00);
  wire slow_done = (slow_cnt_r == 9'h000);
  wire enter_on = (state_nxt == HDC_ST_ON) && (state_r != HDC_ST_ON);
  wire switching = (state_nxt != state_r);
  wire signed [TGT_W+1:0] tgt_s = $signed({2'b00, target_r});
  wire signed [TGT_W+1:0] hy_s = {{(TGT_W - 4){hy.hyst[5]}}, hy.hyst};

  assign hy.load = enter_on;
  assign hy.run = (state_r != HDC_ST_IDLE);
  assign hy.start_val = hyst_start_eff;
  assign hy.end_val = hyst_end_eff;

  // next phase
  always_comb begin
    state_nxt = state_r;
    if (!run_en) begin
      state_nxt = HDC_ST_IDLE;
    end else begin
      case (state_r)
        HDC_ST_IDLE: state_nxt = HDC_ST_ON;
        HDC_ST_ON: if (!blanked && cmp_s2_r) state_nxt = HDC_ST_SLOW1;
        HDC_ST_SLOW1: if (slow_done) state_nxt = HDC_ST_FAST;
        HDC_ST_FAST: if (!blanked && !cmp_s2_r) state_nxt = HDC_ST_SLOW2;
        HDC_ST_SLOW2: if (slow_done) state_nxt = HDC_ST_ON;
        default: state_nxt = HDC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb registers and response
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= HDC_CTRL_RST;
      target_r <= '0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && (!mapped || wr_stat_err);
      if (setup && !pwrite) begin
        prdata_r <= hit_ctrl ? ctrl_r : hit_tgt ? 32'(target_r) : hit_stat ? status : 32'h0;
      end
      if (acc_wr && !pslverr_r && hit_ctrl) begin
        ctrl_r <= pwdata & HDC_CTRL_MASK;
      end
      if (acc_wr && !pslverr_r && hit_tgt) begin
        target_r <= pwdata[TGT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else begin
      cmp_s1_r <= cmp_above;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // phase, timers and bridge drive
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= HDC_ST_IDLE;
      slow_cnt_r <= 9'h000;
      blank_cnt_r <= 6'h00;
      bridge_r <= HDC_BR_OFF;
      active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      active_r <= (state_nxt != HDC_ST_IDLE);
      if (switching) begin
        blank_cnt_r <= blank_len(blank_sel) - 6'h01;
        slow_cnt_r <= slow_len - 9'h001;
      end else begin
        if (blanked) blank_cnt_r <= blank_cnt_r - 6'h01;
        if (!slow_done) slow_cnt_r <= slow_cnt_r - 9'h001;
      end
      case (state_nxt)
        HDC_ST_ON: bridge_r <= HDC_BR_ON;
        HDC_ST_SLOW1: bridge_r <= HDC_BR_SLOW;
        HDC_ST_FAST: bridge_r <= HDC_BR_FAST;
        HDC_ST_SLOW2: bridge_r <= HDC_BR_SLOW;
        default: bridge_r <= HDC_BR_OFF;
      endcase
    end
  end

  // threshold to the sense comparator: above band in on, below band in fast
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_r <= '0;
    end else if (state_nxt == HDC_ST_FAST) begin
      thresh_r <= tgt_s - hy_s;
    end else begin
      thresh_r <= tgt_s + hy_s;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign bridge_drive = bridge_r;
  assign cmp_threshold = thresh_r;
  assign chopper_active = active_r;
endmodule : hdc_chopper

// File: rtl/hdc_hyst_dec.sv
// module: working hysteresis with stepwise decrement
`timescale 1ns/100ps
module hdc_hyst_dec
  import hdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  hdc_hyst_if.dec hy
);
  logic [3:0] div_r;
  logic signed [5:0] hyst_r;
  wire step = (div_r == HDC_DECR_LAST) && (hyst_r > hy.end_val);

  // ----------------------------------------------------------------
  // load at cycle start, then one step down each 16 clocks
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 4'h0;
      hyst_r <= 6'sh00;
    end else if (hy.load) begin
      div_r <= 4'h0;
      hyst_r <= hy.start_val;
    end else if (hy.run) begin
      div_r <= div_r + 4'h1;
      if (step) begin
        hyst_r <= hyst_r - 6'sh01;
      end
    end
  end

  assign hy.hyst = hyst_r;
endmodule : hdc_hyst_dec

// File: rtl/hdc_hyst_if.sv
// interface: hysteresis decrementer control and result
`timescale 1ns/100ps
interface hdc_hyst_if;
  logic load;
  logic run;
  logic signed [5:0] start_val;
  logic signed [5:0] end_val;
  logic signed [5:0] hyst;
  modport ctl (output load, output run, output start_val, output end_val, input hyst);
  modport dec (input load, input run, input start_val, input end_val, output hyst);
endinterface : hdc_hyst_if

// File: rtl/hdc_pkg.sv
// package: constants and types of the hysteresis decay chopper
package hdc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] HDC_OFS_CTRL = 12'h000;
  localparam logic [11:0] HDC_OFS_TARGET = 12'h004;
  localparam logic [11:0] HDC_OFS_STATUS = 12'h008;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int HDC_CTRL_SLOW_LSB = 0; // slow_decay_time_setting, 4 bits
  localparam int HDC_CTRL_BLANK_LSB = 4; // blank_time_select, 2 bits
  localparam int HDC_CTRL_HYST_START_LSB = 8; // hysteresis_start_offset, 3 bits
  localparam int HDC_CTRL_HYST_END_LSB = 12; // hysteresis_end_value, 4 bits
  localparam int HDC_CTRL_MODE_BIT = 16; // chopper_mode_select
  localparam logic [31:0] HDC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HDC_CTRL_MASK = 32'h0001_F73F;
  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int HDC_STAT_PHASE_LSB = 0; // 3 bits
  localparam int HDC_STAT_HYST_LSB = 8; // 6 bits, two's complement
  localparam int HDC_STAT_CMP_BIT = 16;
  // ----------------------------------------------------------------
  // timing counts in system clocks
  // ----------------------------------------------------------------
  localparam logic [8:0] HDC_SLOW_BASE = 9'h00C; // 12 clocks
  localparam int HDC_SLOW_STEP_SH = 5; // times 32
  localparam logic [3:0] HDC_DECR_LAST = 4'hF; // step every 16 clocks
  localparam logic [5:0] HDC_BLANK_0 = 6'h10; // 16
  localparam logic [5:0] HDC_BLANK_1 = 6'h18; // 24
  localparam logic [5:0] HDC_BLANK_2 = 6'h24; // 36
  localparam logic [5:0] HDC_BLANK_3 = 6'h36; // 54
  localparam logic signed [5:0] HDC_HYST_END_BIAS = 6'sh03;
  // ----------------------------------------------------------------
  // phases and bridge drive codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HDC_ST_IDLE = 3'b000,
    HDC_ST_ON = 3'b001,
    HDC_ST_SLOW1 = 3'b010,
    HDC_ST_FAST = 3'b011,
    HDC_ST_SLOW2 = 3'b100
  } hdc_state_t;
  localparam logic [1:0] HDC_BR_OFF = 2'h0; // all transistors off, freewheel
  localparam logic [1:0] HDC_BR_ON = 2'h1; // drive along target polarity
  localparam logic [1:0] HDC_BR_SLOW = 2'h2; // both low sides, recirculate
  localparam logic [1:0] HDC_BR_FAST = 2'h3; // reversed drive
endpackage : hdc_pkg

// File: tb/hdc_chopper_asserts.sv
// checker: phase order, phase timing and bus answers of the chopper
`timescale 1ns/100ps
module hdc_chopper_chk
  import hdc_pkg::*;
#(
  parameter int TGT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmp_above,
  input wire logic [1:0] bridge_drive,
  input wire logic signed [TGT_W+1:0] cmp_threshold,
  input wire logic chopper_active
);
  logic [1:0] prev_r;
  logic [15:0] run_r;
  logic chg;
  // ----------------------------------------------------------------
  // length of the bridge code run that has just ended
  // ----------------------------------------------------------------
  assign chg = bridge_drive != prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= HDC_BR_OFF;
      run_r <= 16'h0000;
    end else begin
      prev_r <= bridge_drive;
      run_r <= chg ? 16'h0001 : run_r + 16'h0001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  chk_apb_answer: assert property (s_setup |=> s_answer)
    else $error("no one-cycle answer after setup");
  chk_phase_next: assert property (chg && prev_r[0] |-> !bridge_drive[0])
    else $error("on or fast phase not followed by slow decay");
  chk_idle_start: assert property (chg && prev_r == HDC_BR_OFF |-> bridge_drive == HDC_BR_ON)
    else $error("chopping did not start with on phase");
  chk_slow_len: assert property (chg && prev_r == HDC_BR_SLOW && bridge_drive != HDC_BR_OFF
    |-> run_r > 16'h002B && run_r[4:0] == 5'h0C)
    else $error("slow decay length wrong");
  chk_on_end: assert property (chg && prev_r == HDC_BR_ON && bridge_drive == HDC_BR_SLOW
    |-> run_r > 16'h000F && ($past(cmp_above, 2) || $past(cmp_above, 3) || $past(cmp_above, 4)))
    else $error("on phase ended without comparator or inside blank");
  chk_fast_end: assert property (chg && prev_r == HDC_BR_FAST && bridge_drive == HDC_BR_SLOW
    |-> run_r > 16'h000F && !($past(cmp_above, 2) && $past(cmp_above, 3) && $past(cmp_above, 4)))
    else $error("fast phase ended without comparator or inside blank");
  chk_active_code: assert property (chopper_active == (bridge_drive != HDC_BR_OFF))
    else $error("active flag disagrees with bridge");
  chk_thr_slow: assert property (!chg && bridge_drive == HDC_BR_SLOW && run_r > 16'h0003
    |-> cmp_threshold == $past(cmp_threshold) || cmp_threshold + 1'b1 == $past(cmp_threshold))
    else $error("threshold moved by more than one step");
endmodule : hdc_chopper_chk
bind hdc_chopper hdc_chopper_chk #(.TGT_W(TGT_W)) u_chk (.*);

// File: tb/hdc_coil_model.sv
// model: coil current and current sense comparator behind the bridge
`timescale 1ns/100ps
module hdc_coil_model
  import hdc_pkg::*;
#(
  parameter int TGT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] bridge_drive,
  input wire logic signed [TGT_W+1:0] cmp_threshold,
  input wire logic [7:0] rate,
  output logic cmp_above
);
  logic signed [15:0] cur_r, cur_nxt, step;
  // drive raises current, fast decay lowers it, recirculation holds it; rate zero stalls at 0
  assign step = $signed({8'h00, rate});
  assign cur_nxt = (rate == 8'h00 || bridge_drive == HDC_BR_OFF) ? 16'sh0000 :
    bridge_drive == HDC_BR_ON ? cur_r + step : bridge_drive == HDC_BR_FAST ? cur_r - step : cur_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r <= 16'sh0000;
    end else begin
      cur_r <= cur_nxt;
    end
  end
  assign cmp_above = cur_r > cmp_threshold;
endmodule : hdc_coil_model

// File: tb/testbench.sv
// testbench: registers, hysteresis, slow timing, blanking and stop of the chopper
`timescale 1ns/100ps
module testbench
  import hdc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmp_above, chopper_active, e;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [1:0] bridge_drive;
  logic signed [9:0] cmp_threshold;
  logic [7:0] rate;
  int fail_count, cmp_count, n;
  hdc_chopper #(.TGT_W(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_above(cmp_above), .bridge_drive(bridge_drive),
    .cmp_threshold(cmp_threshold), .chopper_active(chopper_active));
  hdc_coil_model #(.TGT_W(8)) u_coil (.pclk(pclk), .presetn(presetn), .bridge_drive(bridge_drive),
    .cmp_threshold(cmp_threshold), .rate(rate), .cmp_above(cmp_above));
  // ----------------------------------------------------------------
  // helpers: compare, apb transfer, bridge run length, verdict
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    if (k == 20) begin
      fail_count++;
      $display("Error apb_pready expected 1 seen %b", pready);
      close_out();
    end
  endtask : apb
  task automatic run_of(input logic [1:0] v);
    int k;
    if (pclk) @(negedge pclk); // keep the negedge we may already stand on
    for (k = 0; k < 3000 && bridge_drive !== v; k++)
      @(negedge pclk);
    for (n = 0; k < 3000 && bridge_drive === v; k++) begin
      n++;
      @(negedge pclk);
    end
    if (k == 3000) begin
      fail_count++;
      $display("Error bridge_run expected end of code %0d seen none", v);
      close_out();
    end
  endtask : run_of
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, 32'(HDC_OFS_CTRL), 32'h0000_0000);
    chk("ctrl_rst", 32'h0000_0000, q);
    apb(1'b1, 32'(HDC_OFS_CTRL), 32'hFFFF_FFFF);
    repeat (3) @(negedge pclk);
    chk("classic_idle", 32'h0000_0000, 32'(chopper_active));
    apb(1'b0, 32'(HDC_OFS_CTRL), 32'h0000_0000);
    chk("ctrl_mask", 32'h0001_F73F, q);
    apb(1'b1, 32'(HDC_OFS_STATUS), 32'h0000_0001);
    chk("status_ro", 32'h0000_0001, 32'(e));
    apb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {q[30:0], e});
    $display("t_regs done");
  endtask : t_regs
  task automatic t_hyst;
    logic [31:0] cfg [2] = '{32'h0000_5311, 32'h0000_0602};
    int hs, he;
    apb(1'b1, 32'(HDC_OFS_TARGET), 32'h0000_0064);
    for (int j = 0; j < 2; j++) begin
      he = int'(cfg[j][15:12]) - 3;
      hs = he + int'(cfg[j][10:8]) + 1;
      apb(1'b1, 32'(HDC_OFS_CTRL), cfg[j]);
      run_of(HDC_BR_FAST);
      run_of(HDC_BR_SLOW);
      chk("slow2_len", 32'(12 + 32 * int'(cfg[j][3:0])), 32'(n));
      @(negedge pclk);
      chk("thr_start", 32'(100 + hs), 32'(cmp_threshold));
      @(posedge pclk);
      rate <= 8'h00;
      repeat (140) @(negedge pclk);
      chk("thr_end", 32'(100 + he), 32'(cmp_threshold));
      apb(1'b0, 32'(HDC_OFS_STATUS), 32'h0000_0000);
      chk("status", {16'h0000, 2'h0, 6'(he), 5'h00, 3'h1}, q & 32'h0000_3F07);
      rate <= 8'h01;
      run_of(HDC_BR_SLOW);
      chk("slow1_len", 32'(12 + 32 * int'(cfg[j][3:0])), 32'(n));
    end
    $display("t_hyst done");
  endtask : t_hyst
  task automatic t_blank;
    int bl [4] = '{16, 24, 36, 54};
    @(posedge pclk);
    rate <= 8'd200;
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, 32'(HDC_OFS_CTRL), 32'h0000_0001 | 32'(t << 4));
      run_of(HDC_BR_ON);
      run_of(HDC_BR_ON);
      chk("on_blank", 32'h0000_0001, 32'(n >= bl[t] && n <= bl[t] + 4));
    end
    $display("t_blank done");
  endtask : t_blank
  task automatic t_off;
    apb(1'b1, 32'(HDC_OFS_CTRL), 32'h0000_0000);
    repeat (3) @(negedge pclk);
    chk("freewheel", 32'h0000_0000, {29'h0, chopper_active, bridge_drive});
    $display("t_off done");
  endtask : t_off
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata} = 64'h0000_0000_0000_0000;
    rate = 8'h01;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_hyst();
    t_blank();
    t_off();
    close_out();
  end
endmodule : testbench
